// >>> core/ptp_regs_pkg.sv
// Purpose: Shared constants for the per-port timestamp adjust register bank.
// Assumes: Avalon-MM byte addresses, one aligned 32-bit word per register.
// Notes: Bank codes with the top bit set are reserved and never answer.
package ptp_regs_pkg;

    // ==========================================================
    // Sizes
    localparam int NPORT = 3;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int WORD_LSB = 2;
    localparam int LAT_W = 16;
    localparam int CNT_W = 3;
    localparam int TIME_W = 32;
    localparam int PORT_W = 2;
    localparam int BANK_W = 3;

    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_SEL = 9'h154;
    localparam logic [ADDR_W-1:0] ADDR_LAT = 9'h158;
    localparam logic [ADDR_W-1:0] ADDR_ASYM = 9'h15C;
    localparam logic [ADDR_W-1:0] ADDR_CAP = 9'h160;
    localparam logic [ADDR_W-1:0] ADDR_RELEASE = 9'h164;
    localparam logic [ADDR_W-1:0] ADDR_CMD = 9'h168;

    // ==========================================================
    // Field positions
    localparam int SEL_BANK_LSB = 0;
    localparam int SEL_PORT_LSB = 4;
    localparam int TX_LAT_LSB = 16;
    localparam int RX_LAT_LSB = 0;
    localparam int ASYM_LSB = 16;
    localparam int PEER_LSB = 0;
    localparam int CNT_RX_LSB = 0;
    localparam int CNT_TX_LSB = 4;
    localparam int CMD_ENABLE_BIT = 0;

    // ==========================================================
    // Reset values
    localparam logic [LAT_W-1:0] LAT_PORT0_RST = 16'h0014;
    localparam logic [LAT_W-1:0] TX_LAT_RST = 16'h005F;
    localparam logic [LAT_W-1:0] RX_LAT_RST = 16'h011D;
    localparam logic [DATA_W-1:0] ASYM_RST = 32'h00000000;
    localparam logic [BANK_W-1:0] SEL_BANK_RST = 3'h0;
    localparam logic [PORT_W-1:0] SEL_PORT_RST = 2'h0;

    typedef enum logic [BANK_W-1:0] {
        BANK_GENERAL = 3'b000,
        BANK_RX = 3'b001,
        BANK_TX = 3'b010,
        BANK_GPIO = 3'b011
    } bank_t;

endpackage

// >>> core/stamp_counter.sv
// Purpose: Saturating up/down count of timestamps held for one direction.
// Assumes: inc_i and dec_i are one-cycle pulses.
// Notes: Both in one cycle leave the count unchanged.
module stamp_counter #(
    parameter int W = 3
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic inc_i,
    input wire logic dec_i,
    output logic [W-1:0] count_o
);

    logic [W-1:0] next_count;

    always_comb
    begin
        next_count = count_o;
        // Saturate at both ends so a stray release cannot wrap to full
        if (inc_i && !dec_i && count_o != {W{1'b1}})
        begin
            next_count = count_o + {{(W-1){1'b0}}, 1'b1};
        end
        else if (dec_i && !inc_i && count_o != {W{1'b0}})
        begin
            next_count = count_o - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            count_o <= {W{1'b0}};
        end
        else
        begin
            count_o <= next_count;
        end
    end

endmodule

// >>> core/ptp_port_timestamp_adjust_regs.sv
// Purpose: Per-port latency, asymmetry and capture count registers, and
//          latency correction of captured egress and ingress times.
// Assumes: Avalon-MM slave with byte address; answer one cycle after request.
// Notes: Per-port registers answer only with the general bank selected; release writes act in any bank.
//
// Overview of operation
// - Port registers share space, steered by selects
// - Bank field 2:0 selects general, rx, tx, gpio
// - Port field 5:4 picks port instance accessed
// - Bits 31:16 hold transmit path latency ns
// - Bits 15:0 hold receive path latency ns
// - Ports 1,2 reset to 95 and 285
// - Port 0 resets both latencies to 20
// - Bits 31:16 signed asymmetry, reset zero
// - Bits 15:0 peer delay, reset zero
// - Capture info register is read-only counts
// - Egress count bits 6:4, up/down
// - Ingress count bits 2:0, up/down
module ptp_port_timestamp_adjust_regs
    import ptp_regs_pkg::*;
#(
    parameter int NP = NPORT
) (
    input wire logic mclk_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [DATA_W-1:0] avs_writedata_i,
    input wire logic [BE_W-1:0] avs_byteenable_i,
    output logic [DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic egress_evt_i,
    input wire logic [PORT_W-1:0] egress_port_i,
    input wire logic [TIME_W-1:0] egress_time_i,
    input wire logic ingress_evt_i,
    input wire logic [PORT_W-1:0] ingress_port_i,
    input wire logic [TIME_W-1:0] ingress_time_i,
    output logic egress_stamp_valid_o,
    output logic [PORT_W-1:0] egress_stamp_port_o,
    output logic [TIME_W-1:0] egress_stamp_o,
    output logic ingress_stamp_valid_o,
    output logic [PORT_W-1:0] ingress_stamp_port_o,
    output logic [TIME_W-1:0] ingress_stamp_o,
    output logic timing_enable_o
);

    // ==========================================================
    // Helpers
    function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [BE_W-1:0] be);
        logic [DATA_W-1:0] r;
        r = old_v;
        for (int b = 0; b < BE_W; b++)
        begin
            if (be[b])
            begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a[ADDR_W-1:WORD_LSB] == off[ADDR_W-1:WORD_LSB];
    endfunction

    function automatic logic [DATA_W-1:0] lat_reset(input int p);
        if (p == 0)
        begin
            return {LAT_PORT0_RST, LAT_PORT0_RST};
        end
        return {TX_LAT_RST, RX_LAT_RST};
    endfunction

    function automatic logic port_ok(input logic [PORT_W-1:0] p);
        return 32'(p) < NP;
    endfunction

    // ==========================================================
    // State
    logic [DATA_W-1:0] lat [NP];
    logic [DATA_W-1:0] asym [NP];
    logic [DATA_W-1:0] next_lat [NP];
    logic [DATA_W-1:0] next_asym [NP];
    logic [BANK_W-1:0] sel_bank;
    logic [PORT_W-1:0] sel_port;
    logic [BANK_W-1:0] next_sel_bank;
    logic [PORT_W-1:0] next_sel_port;
    logic next_enable;
    logic next_wait;
    logic [DATA_W-1:0] next_rdata;
    logic [CNT_W-1:0] rx_cnt [NP];
    logic [CNT_W-1:0] tx_cnt [NP];
    logic [NP-1:0] rx_inc;
    logic [NP-1:0] tx_inc;
    logic [NP-1:0] rx_dec;
    logic [NP-1:0] tx_dec;
    logic wr_done;
    logic port_access;
    logic [LAT_W-1:0] tx_lat_sel;
    logic [LAT_W-1:0] rx_lat_sel;

    // A write takes effect only on the cycle its wait has dropped
    assign wr_done = avs_write_i && !avs_waitrequest_o;
    assign port_access = (sel_bank == BANK_GENERAL) && port_ok(sel_port);

    // ==========================================================
    // Bus slave and register writes
    always_comb
    begin
        next_wait = avs_waitrequest_o ? !(avs_read_i || avs_write_i) : 1'b1;
        next_rdata = avs_readdata_o;
        next_sel_bank = sel_bank;
        next_sel_port = sel_port;
        next_enable = timing_enable_o;
        for (int p = 0; p < NP; p++)
        begin
            next_lat[p] = lat[p];
            next_asym[p] = asym[p];
            rx_dec[p] = 1'b0;
            tx_dec[p] = 1'b0;
        end
        if (avs_read_i && avs_waitrequest_o)
        begin
            next_rdata = {DATA_W{1'b0}};
            if (reg_hit(avs_address_i, ADDR_SEL))
            begin
                next_rdata[SEL_BANK_LSB +: BANK_W] = sel_bank;
                next_rdata[SEL_PORT_LSB +: PORT_W] = sel_port;
            end
            else if (reg_hit(avs_address_i, ADDR_CMD))
            begin
                next_rdata[CMD_ENABLE_BIT] = timing_enable_o;
            end
            else if (port_access)
            begin
                if (reg_hit(avs_address_i, ADDR_LAT))
                begin
                    next_rdata = lat[sel_port];
                end
                else if (reg_hit(avs_address_i, ADDR_ASYM))
                begin
                    next_rdata = asym[sel_port];
                end
                else if (reg_hit(avs_address_i, ADDR_CAP))
                begin
                    next_rdata[CNT_RX_LSB +: CNT_W] = rx_cnt[sel_port];
                    next_rdata[CNT_TX_LSB +: CNT_W] = tx_cnt[sel_port];
                end
            end
        end
        if (wr_done)
        begin
            if (reg_hit(avs_address_i, ADDR_SEL) && avs_byteenable_i[0])
            begin
                next_sel_bank = avs_writedata_i[SEL_BANK_LSB +: BANK_W];
                next_sel_port = avs_writedata_i[SEL_PORT_LSB +: PORT_W];
            end
            else if (reg_hit(avs_address_i, ADDR_CMD) && avs_byteenable_i[0])
            begin
                next_enable = avs_writedata_i[CMD_ENABLE_BIT];
            end
            else if (reg_hit(avs_address_i, ADDR_RELEASE) && avs_byteenable_i[0] && port_ok(sel_port))
            begin
                rx_dec[sel_port] = |avs_writedata_i[CNT_RX_LSB +: CNT_W];
                tx_dec[sel_port] = |avs_writedata_i[CNT_TX_LSB +: CNT_W];
            end
            else if (port_access && reg_hit(avs_address_i, ADDR_LAT))
            begin
                next_lat[sel_port] = be_merge(lat[sel_port], avs_writedata_i, avs_byteenable_i);
            end
            else if (port_access && reg_hit(avs_address_i, ADDR_ASYM))
            begin
                next_asym[sel_port] = be_merge(asym[sel_port], avs_writedata_i, avs_byteenable_i);
            end
            // Capture counts ignore writes; unmapped words likewise
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= {DATA_W{1'b0}};
            sel_bank <= SEL_BANK_RST;
            sel_port <= SEL_PORT_RST;
            timing_enable_o <= 1'b0;
            for (int p = 0; p < NP; p++)
            begin
                lat[p] <= lat_reset(p);
                asym[p] <= ASYM_RST;
            end
        end
        else
        begin
            avs_waitrequest_o <= next_wait;
            avs_readdata_o <= next_rdata;
            sel_bank <= next_sel_bank;
            sel_port <= next_sel_port;
            timing_enable_o <= next_enable;
            for (int p = 0; p < NP; p++)
            begin
                lat[p] <= next_lat[p];
                asym[p] <= next_asym[p];
            end
        end
    end

    // ==========================================================
    // Timestamp correction and counts
    // Latencies are read live; software keeps them still while enabled
    assign tx_lat_sel = port_ok(egress_port_i) ? lat[egress_port_i][TX_LAT_LSB +: LAT_W] : {LAT_W{1'b0}};
    assign rx_lat_sel = port_ok(ingress_port_i) ? lat[ingress_port_i][RX_LAT_LSB +: LAT_W] : {LAT_W{1'b0}};

    always_comb
    begin
        for (int p = 0; p < NP; p++)
        begin
            tx_inc[p] = timing_enable_o && egress_evt_i && 32'(egress_port_i) == p;
            rx_inc[p] = timing_enable_o && ingress_evt_i && 32'(ingress_port_i) == p;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            egress_stamp_valid_o <= 1'b0;
            egress_stamp_port_o <= {PORT_W{1'b0}};
            egress_stamp_o <= {TIME_W{1'b0}};
            ingress_stamp_valid_o <= 1'b0;
            ingress_stamp_port_o <= {PORT_W{1'b0}};
            ingress_stamp_o <= {TIME_W{1'b0}};
        end
        else
        begin
            // Port 3 still stamps, with no latency and no count
            egress_stamp_valid_o <= timing_enable_o && egress_evt_i;
            egress_stamp_port_o <= egress_port_i;
            egress_stamp_o <= egress_time_i + TIME_W'(tx_lat_sel);
            ingress_stamp_valid_o <= timing_enable_o && ingress_evt_i;
            ingress_stamp_port_o <= ingress_port_i;
            ingress_stamp_o <= ingress_time_i - TIME_W'(rx_lat_sel);
        end
    end

    for (genvar g = 0; g < NP; g++)
    begin : g_cnt
        stamp_counter #(.W(CNT_W)) u_rx (
            .mclk_i(mclk_i),
            .arst_n_i(arst_n_i),
            .inc_i(rx_inc[g]),
            .dec_i(rx_dec[g]),
            .count_o(rx_cnt[g])
        );
        stamp_counter #(.W(CNT_W)) u_tx (
            .mclk_i(mclk_i),
            .arst_n_i(arst_n_i),
            .inc_i(tx_inc[g]),
            .dec_i(tx_dec[g]),
            .count_o(tx_cnt[g])
        );
    end

    // ==========================================================
    // Checks
    logic untouched;
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            untouched <= 1'b1;
        end
        else if (wr_done && (reg_hit(avs_address_i, ADDR_LAT) || reg_hit(avs_address_i, ADDR_ASYM)))
        begin
            untouched <= 1'b0;
        end
    end

    a_bank_gate: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (avs_read_i && !avs_waitrequest_o && reg_hit(avs_address_i, ADDR_LAT) && sel_bank != BANK_GENERAL)
        |-> avs_readdata_o == {DATA_W{1'b0}})
        else $error("latency register answered outside the general bank");
    a_sel_write: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (wr_done && reg_hit(avs_address_i, ADDR_SEL) && avs_byteenable_i[0])
        |=> sel_bank == $past(avs_writedata_i[SEL_BANK_LSB +: BANK_W])
            && sel_port == $past(avs_writedata_i[SEL_PORT_LSB +: PORT_W]))
        else $error("select fields did not take the written value");
    a_tx_stamp: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (egress_evt_i && timing_enable_o)
        |=> egress_stamp_valid_o && egress_stamp_o == $past(egress_time_i) + TIME_W'($past(tx_lat_sel)))
        else $error("egress stamp not corrected by transmit latency");
    a_rx_stamp: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (ingress_evt_i && timing_enable_o)
        |=> ingress_stamp_valid_o && ingress_stamp_o == $past(ingress_time_i) - TIME_W'($past(rx_lat_sel)))
        else $error("ingress stamp not corrected by receive latency");
    a_lat_default: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        untouched |-> lat[0] == {LAT_PORT0_RST, LAT_PORT0_RST} && lat[1] == {TX_LAT_RST, RX_LAT_RST})
        else $error("latency default lost without a write");
    a_asym_zero: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        untouched |-> asym[0] == ASYM_RST && asym[NP-1] == ASYM_RST)
        else $error("asymmetry register not zero after reset");
    a_cap_read: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (avs_read_i && avs_waitrequest_o && reg_hit(avs_address_i, ADDR_CAP) && port_access)
        |=> !avs_waitrequest_o && avs_readdata_o[CNT_RX_LSB +: CNT_W] == $past(rx_cnt[sel_port])
            && avs_readdata_o[CNT_TX_LSB +: CNT_W] == $past(tx_cnt[sel_port]))
        else $error("capture counts read back wrong");
    a_rx_count_up: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (rx_inc[0] && !rx_dec[0] && rx_cnt[0] != {CNT_W{1'b1}})
        |=> rx_cnt[0] == $past(rx_cnt[0]) + 3'h1)
        else $error("ingress count did not rise");
    a_tx_count_down: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
        (tx_dec[0] && !tx_inc[0] && tx_cnt[0] != {CNT_W{1'b0}})
        |=> tx_cnt[0] == $past(tx_cnt[0]) - 3'h1)
        else $error("egress count did not fall");

endmodule

// >>> bench/ptp_port_timestamp_adjust_regs_bench.sv
// Purpose: Self-checking bench for the per-port timestamp adjust registers.
// Assumes: Avalon-MM master waits on waitrequest; latencies only change while timing is off.
// Notes: Expected values come from the documented numbers, not from the design.
module ptp_port_timestamp_adjust_regs_bench
    import ptp_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Clock, reset and design
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [DATA_W-1:0] avs_writedata_i = '0;
    logic [BE_W-1:0] avs_byteenable_i = '0;
    logic [DATA_W-1:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic egress_evt_i = 1'b0;
    logic [PORT_W-1:0] egress_port_i = '0;
    logic [TIME_W-1:0] egress_time_i = '0;
    logic ingress_evt_i = 1'b0;
    logic [PORT_W-1:0] ingress_port_i = '0;
    logic [TIME_W-1:0] ingress_time_i = '0;
    logic egress_stamp_valid_o;
    logic [PORT_W-1:0] egress_stamp_port_o;
    logic [TIME_W-1:0] egress_stamp_o;
    logic ingress_stamp_valid_o;
    logic [PORT_W-1:0] ingress_stamp_port_o;
    logic [TIME_W-1:0] ingress_stamp_o;
    logic timing_enable_o;
    int err_count = 0;
    int total_checks = 0;

    always #2 mclk_i = ~mclk_i;

    ptp_port_timestamp_adjust_regs #(.NP(3)) i_ptp_port_timestamp_adjust_regs (
        .mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .egress_evt_i(egress_evt_i), .egress_port_i(egress_port_i), .egress_time_i(egress_time_i),
        .ingress_evt_i(ingress_evt_i), .ingress_port_i(ingress_port_i), .ingress_time_i(ingress_time_i),
        .egress_stamp_valid_o(egress_stamp_valid_o), .egress_stamp_port_o(egress_stamp_port_o),
        .egress_stamp_o(egress_stamp_o), .ingress_stamp_valid_o(ingress_stamp_valid_o),
        .ingress_stamp_port_o(ingress_stamp_port_o), .ingress_stamp_o(ingress_stamp_o),
        .timing_enable_o(timing_enable_o)
    );

    // ==========================================================
    // Shared tasks
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
        begin
            $display("All tests passed");
        end
        else
        begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Request is held until the edge that samples waitrequest low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic [BE_W-1:0] be, output logic [DATA_W-1:0] q);
        @(posedge mclk_i);
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        // Only the watchdog ends a wait that never gets an answer
        do
        begin
            @(posedge mclk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic [BE_W-1:0] be = 4'hF);
        logic [DATA_W-1:0] q;
        bus(1'b1, a, d, be, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string msg);
        logic [DATA_W-1:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        chk(q, exp, msg);
    endtask

    task automatic sel(input logic [2:0] bank, input logic [1:0] port);
        wr(ADDR_SEL, {26'h0, port, 1'b0, bank});
    endtask

    // One capture event, judged in the cycle after it is taken
    task automatic ev(input logic eg, input logic [1:0] p, input logic [31:0] t,
                      input logic expv, input logic [31:0] exp);
        @(posedge mclk_i);
        if (eg)
        begin
            egress_evt_i <= 1'b1;
            egress_port_i <= p;
            egress_time_i <= t;
        end
        else
        begin
            ingress_evt_i <= 1'b1;
            ingress_port_i <= p;
            ingress_time_i <= t;
        end
        @(posedge mclk_i);
        egress_evt_i <= 1'b0;
        ingress_evt_i <= 1'b0;
        #1;
        chk({31'h0, eg ? egress_stamp_valid_o : ingress_stamp_valid_o}, {31'h0, expv}, "stamp valid");
        // Stamp and port are registered every cycle, enabled or not
        chk(eg ? egress_stamp_o : ingress_stamp_o, exp, "stamp value");
        chk({30'h0, eg ? egress_stamp_port_o : ingress_stamp_port_o}, {30'h0, p}, "stamp port");
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        for (int p = 0; p < 3; p++)
        begin
            sel(3'h0, p[1:0]);
            rd(ADDR_SEL, {26'h0, p[1:0], 4'h0}, "select readback");
            rd(ADDR_LAT, (p == 0) ? 32'h00140014 : 32'h005F011D, "latency default");
            rd(ADDR_ASYM, 32'h00000000, "asym default");
            rd(ADDR_CAP, 32'h00000000, "count default");
        end
    endtask

    task automatic t_rw();
        sel(3'h0, 2'h1);
        wr(ADDR_LAT, 32'h0473068A);
        rd(ADDR_LAT, 32'h0473068A, "latency write");
        wr(ADDR_LAT, 32'h0044FFFF, 4'hC);
        rd(ADDR_LAT, 32'h0044068A, "upper half write");
        wr(ADDR_ASYM, 32'hFFF60064);
        rd(ADDR_ASYM, 32'hFFF60064, "asym write");
        sel(3'h0, 2'h2);
        rd(ADDR_LAT, 32'h005F011D, "other port untouched");
        sel(3'h0, 2'h3);
        wr(ADDR_LAT, 32'h12345678);
        rd(ADDR_LAT, 32'h00000000, "port 3 absent");
    endtask

    task automatic t_bank();
        for (int b = 1; b < 8; b++)
        begin
            sel(b[2:0], 2'h1);
            rd(ADDR_LAT, 32'h00000000, "other bank read");
            wr(ADDR_LAT, 32'hA5A5A5A5);
        end
        sel(3'h0, 2'h1);
        rd(ADDR_LAT, 32'h0044068A, "other bank write ignored");
    endtask

    task automatic t_stamp();
        sel(3'h0, 2'h1);
        ev(1'b1, 2'h1, 32'h00010000, 1'b0, 32'h00010044);
        rd(ADDR_CAP, 32'h00000000, "no count while off");
        wr(ADDR_CMD, 32'h00000001);
        // Enable is written at the edge wr returns on; let it settle
        #1;
        chk({31'h0, timing_enable_o}, 32'h1, "enable level");
        ev(1'b1, 2'h1, 32'h00010000, 1'b1, 32'h00010044);
        ev(1'b1, 2'h1, 32'hFFFFFFF0, 1'b1, 32'h00000034);
        ev(1'b0, 2'h1, 32'h00010000, 1'b1, 32'h0000F976);
        ev(1'b1, 2'h3, 32'h00000100, 1'b1, 32'h00000100);
        ev(1'b0, 2'h0, 32'h00000100, 1'b1, 32'h000000EC);
        ev(1'b1, 2'h0, 32'h00000100, 1'b1, 32'h00000114);
        rd(ADDR_CAP, 32'h00000021, "counts after events");
        wr(ADDR_CAP, 32'h00000000);
        rd(ADDR_CAP, 32'h00000021, "counts read-only");
        wr(ADDR_RELEASE, 32'h00000011);
        rd(ADDR_CAP, 32'h00000010, "counts after release");
        wr(ADDR_RELEASE, 32'h00000010);
        rd(ADDR_CAP, 32'h00000000, "egress drained");
        sel(3'h0, 2'h0);
        rd(ADDR_CAP, 32'h00000011, "port 0 counts");
        wr(ADDR_RELEASE, 32'h00000010);
        rd(ADDR_CAP, 32'h00000001, "port 0 ingress count");
        wr(ADDR_CMD, 32'h00000000);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_rw();
        t_bank();
        t_stamp();
        end_sim();
    end

    // Whole run is well under a thousand cycles
    initial
    begin
        #40000;
        err_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_sim();
    end

endmodule
